// ---- core/sch_if.sv ----
// Interface joining the platform end and the socket end
`timescale 1ns/1ps
interface sch_if;
    import sch_pkg::*;
    logic refclk_pll_locked;
    logic refclk_valid_flag;
    logic frontend_setup_done;
    logic setup_prepare_request;
    logic setup_prepare_ack;
    logic socket_reset;
    logic [SCH_PORTS-1:0] port_supply_enable;
    logic [SCH_PORTS-1:0] port_supply_ok;
    logic [SCH_PORTS-1:0] optic_supply_enable;
    logic [SCH_PORTS-1:0] optic_supply_ok;
    logic [SCH_PROBES-1:0] debug_clock_probes;
    logic spare_clock_output;
    // Platform end
    modport platform (
        output refclk_pll_locked,
        output refclk_valid_flag,
        output frontend_setup_done,
        output setup_prepare_request,
        input setup_prepare_ack,
        input socket_reset,
        input port_supply_enable,
        output port_supply_ok,
        input optic_supply_enable,
        output optic_supply_ok,
        input debug_clock_probes,
        input spare_clock_output
    );
    // Socket end
    modport socket (
        input refclk_pll_locked,
        input refclk_valid_flag,
        input frontend_setup_done,
        input setup_prepare_request,
        output setup_prepare_ack,
        output socket_reset,
        output port_supply_enable,
        input port_supply_ok,
        output optic_supply_enable,
        input optic_supply_ok,
        output debug_clock_probes,
        output spare_clock_output
    );
endinterface

// ---- core/sch_pkg.sv ----
// Shared constants and types for the socket clock and power handshake
package sch_pkg;
    // Number of cable ports and debug clock probes
    localparam int SCH_PORTS = 6;
    localparam int SCH_PROBES = 6;
    // Base clock and bus clock figures
    localparam int SCH_BASE_CLK_MHZ = 40;
    localparam int SCH_ACLK_MHZ = 50;
    // Self-configuration duration, in microseconds, and derived cycles
    localparam int SCH_SETUP_TIME_US = 10;
    localparam int SCH_SETUP_CYCLES = SCH_SETUP_TIME_US * SCH_BASE_CLK_MHZ;
    // Width of the probe edge counters
    localparam int SCH_CNT_W = 16;
    // Register offsets of the socket controller
    localparam logic [7:0] SCH_REG_CTRL = 8'h00;
    localparam logic [7:0] SCH_REG_STAT = 8'h04;
    localparam logic [7:0] SCH_REG_IRQ = 8'h08;
    localparam logic [7:0] SCH_REG_MASK = 8'h0c;
    // Control field positions
    localparam int SCH_CTRL_PORT_LSB = 0;
    localparam int SCH_CTRL_OPTIC_LSB = 8;
    // Status field positions
    localparam int SCH_STAT_PORT_OK_LSB = 0;
    localparam int SCH_STAT_OPTIC_OK_LSB = 8;
    localparam int SCH_STAT_DONE_BIT = 16;
    localparam int SCH_STAT_CLK_OK_BIT = 17;
    // Interrupt bit positions
    localparam int SCH_IRQ_VALID_RISE = 0;
    localparam int SCH_IRQ_DONE_RISE = 1;
    localparam int SCH_IRQ_PORT_DROP = 2;
    localparam int SCH_IRQ_OPTIC_DROP = 3;
    localparam int SCH_IRQ_W = 4;
    // Reset values
    localparam logic [31:0] SCH_CTRL_RESET = 32'h0000_0000;
    localparam logic [SCH_IRQ_W-1:0] SCH_MASK_RESET = 4'h0;
    // Slave okay and error responses
    localparam logic [1:0] SCH_RESP_OKAY = 2'b00;
    localparam logic [1:0] SCH_RESP_SLVERR = 2'b10;
    // Platform self-configuration states
    typedef enum logic [1:0] {SCH_IDLE, SCH_SETUP, SCH_DONE} sch_state_e;
endpackage

// ---- core/sch_platform.sv ----
// Platform end: clock health flags, self-configuration, supply returns
`timescale 1ns/1ps
module sch_platform (
    input wire logic base_clock_40mhz,
    input wire logic pll_locked_in,
    input wire logic input_clock_ok,
    input wire logic [sch_pkg::SCH_PORTS-1:0] port_overpower,
    input wire logic [sch_pkg::SCH_PORTS-1:0] optic_overpower,
    output logic [sch_pkg::SCH_CNT_W-1:0] probe_count [sch_pkg::SCH_PROBES],
    sch_if.platform link
);
    import sch_pkg::*;

    logic reset_d_ff, nxt_reset_d, done_ff, nxt_done;
    sch_state_e state_ff, nxt_state;
    logic [15:0] cnt_ff, nxt_cnt;
    logic [SCH_PORTS-1:0] port_ok_ff, nxt_port_ok, optic_ok_ff, nxt_optic_ok;

    ////////////////////////////////////////////////////////////////////////
    // Clock health flags are combinational, untimed; valid is also gated by pll lock
    assign link.refclk_pll_locked = pll_locked_in;
    assign link.refclk_valid_flag = input_clock_ok & pll_locked_in;
    // Prepare is reserved and held low
    assign link.setup_prepare_request = 1'b0;
    assign link.frontend_setup_done = done_ff;

    ////////////////////////////////////////////////////////////////////////
    // Self-configuration; a socket reset release restarts it
    always_comb
    begin
        nxt_reset_d = link.socket_reset;
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_done = done_ff;
        case (state_ff)
            SCH_IDLE:
            begin
                nxt_state = SCH_SETUP;
                nxt_cnt = 16'h0000;
            end
            SCH_SETUP:
            begin
                if (cnt_ff == 16'(SCH_SETUP_CYCLES - 1))
                begin
                    nxt_state = SCH_DONE;
                    nxt_done = 1'b1;
                end
                else
                begin
                    nxt_cnt = cnt_ff + 16'h0001;
                end
            end
            SCH_DONE: nxt_done = 1'b1;
            default: nxt_state = SCH_IDLE;
        endcase
        // Falling socket reset reruns configuration unconditionally
        if (reset_d_ff && !link.socket_reset)
        begin
            nxt_state = SCH_SETUP;
            nxt_cnt = 16'h0000;
            nxt_done = 1'b0;
        end
    end

    always_ff @(posedge base_clock_40mhz)
    begin
        reset_d_ff <= nxt_reset_d;
        state_ff <= nxt_state;
        cnt_ff <= nxt_cnt;
        done_ff <= nxt_done;
    end

    ////////////////////////////////////////////////////////////////////////
    // Power-good follows enable, dropped on over-power at any time
    always_comb
    begin
        nxt_port_ok = link.port_supply_enable & ~port_overpower;
        nxt_optic_ok = link.optic_supply_enable & ~optic_overpower;
    end

    always_ff @(posedge base_clock_40mhz)
    begin
        port_ok_ff <= nxt_port_ok;
        optic_ok_ff <= nxt_optic_ok;
    end

    assign link.port_supply_ok = port_ok_ff;
    assign link.optic_supply_ok = optic_ok_ff;

    ////////////////////////////////////////////////////////////////////////
    // One edge counter per debug probe, each on its own clock
    genvar gi;
    generate
        for (gi = 0; gi < SCH_PROBES; gi++)
        begin : g_probe
            logic [SCH_CNT_W-1:0] pc_ff;
            always_ff @(posedge link.debug_clock_probes[gi])
            begin
                // Cleared in socket reset so counts start known
                pc_ff <= link.socket_reset ? '0 : pc_ff + 1'b1;
            end
            assign probe_count[gi] = pc_ff;
        end
    endgenerate
endmodule

// ---- core/sch_socket.sv ----
// Socket end: clock logic reset, supply enables, AXI4-Lite control registers
`timescale 1ns/1ps
module sch_socket (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic base_clock_40mhz,
    input wire logic [sch_pkg::SCH_PROBES-1:0] user_clocks,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic refclk_logic_reset,
    output logic irq,
    sch_if.socket link
);
    import sch_pkg::*;

    logic [1:0] vld_sync_ff, nxt_vld_sync, lck_sync_ff, nxt_lck_sync;
    logic [1:0] done_sync_ff, nxt_done_sync, bresp_ff, nxt_bresp;
    logic [1:0] rresp_ff, nxt_rresp;
    logic vld_d_ff, nxt_vld_d, done_d_ff, nxt_done_d, clk_reset_ff;
    logic nxt_clk_reset, aw_hold_ff, nxt_aw_hold, w_hold_ff, nxt_w_hold;
    logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid, do_write;
    logic [SCH_PORTS-1:0] pok_d_ff, nxt_pok_d, ook_d_ff, nxt_ook_d;
    logic [SCH_IRQ_W-1:0] irq_ff, nxt_irq, mask_ff, nxt_mask, events;
    logic [31:0] ctrl_ff, nxt_ctrl, w_data_ff, nxt_w_data, rdata_ff;
    logic [31:0] nxt_rdata, status_word, ctrl_word;
    logic [7:0] aw_addr_ff, nxt_aw_addr;
    logic [3:0] w_strb_ff, nxt_w_strb;

    // Byte-lane merge used for the control and mask registers
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
        for (int i = 0; i < 4; i++)
            if (strb[i])
                old[i*8 +: 8] = data[i*8 +: 8];
        return old;
    endfunction

    function automatic logic known(input logic [7:0] a);
        return (a == SCH_REG_CTRL) || (a == SCH_REG_STAT) ||
               (a == SCH_REG_IRQ) || (a == SCH_REG_MASK);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin drives on the link: ack echoes prepare, spare held low, socket reset from aresetn
    assign link.setup_prepare_ack = link.setup_prepare_request;
    assign link.spare_clock_output = 1'b0;
    assign link.socket_reset = ~aresetn;
    // Probes carry the user clocks to the platform counters
    assign link.debug_clock_probes = user_clocks;
    // Software chooses which ports run optics and need supply
    assign link.port_supply_enable =
        ctrl_ff[SCH_CTRL_PORT_LSB +: SCH_PORTS];
    assign link.optic_supply_enable =
        ctrl_ff[SCH_CTRL_OPTIC_LSB +: SCH_PORTS];

    ////////////////////////////////////////////////////////////////////////
    // Synchronise the valid, lock and done flags; clock logic held in reset until safe
    always_comb
    begin
        nxt_vld_sync = {vld_sync_ff[0], link.refclk_valid_flag};
        nxt_lck_sync = {lck_sync_ff[0], link.refclk_pll_locked};
        nxt_done_sync = {done_sync_ff[0], link.frontend_setup_done};
        nxt_vld_d = vld_sync_ff[1];
        nxt_done_d = done_sync_ff[1];
        nxt_pok_d = link.port_supply_ok;
        nxt_ook_d = link.optic_supply_ok;
        // Valid rising also forces one reset cycle to relock
        nxt_clk_reset = !(vld_sync_ff[1] && lck_sync_ff[1]) ||
                        !done_sync_ff[1] ||
                        (vld_sync_ff[1] && !vld_d_ff);
        if (!aresetn)
        begin
            nxt_vld_sync = 2'b00;
            nxt_lck_sync = 2'b00;
            nxt_done_sync = 2'b00;
            nxt_vld_d = 1'b0;
            nxt_done_d = 1'b0;
            nxt_pok_d = '0;
            nxt_ook_d = '0;
            nxt_clk_reset = 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        vld_sync_ff <= nxt_vld_sync;
        lck_sync_ff <= nxt_lck_sync;
        done_sync_ff <= nxt_done_sync;
        vld_d_ff <= nxt_vld_d;
        done_d_ff <= nxt_done_d;
        pok_d_ff <= nxt_pok_d;
        ook_d_ff <= nxt_ook_d;
        clk_reset_ff <= nxt_clk_reset;
    end

    assign refclk_logic_reset = clk_reset_ff;

    ////////////////////////////////////////////////////////////////////////
    // Events; supply drops are only reported, never fatal
    // Power-good is sampled directly: a one-cycle glitch may be missed
    always_comb
    begin
        events = '0;
        events[SCH_IRQ_VALID_RISE] = vld_sync_ff[1] & ~vld_d_ff;
        events[SCH_IRQ_DONE_RISE] = done_sync_ff[1] & ~done_d_ff;
        events[SCH_IRQ_PORT_DROP] =
            |(pok_d_ff & ~link.port_supply_ok);
        events[SCH_IRQ_OPTIC_DROP] = |(ook_d_ff & ~link.optic_supply_ok);
    end

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[SCH_STAT_PORT_OK_LSB +: SCH_PORTS] = link.port_supply_ok;
        status_word[SCH_STAT_OPTIC_OK_LSB +: SCH_PORTS] =
            link.optic_supply_ok;
        status_word[SCH_STAT_DONE_BIT] = done_sync_ff[1];
        status_word[SCH_STAT_CLK_OK_BIT] = ~clk_reset_ff;
        // Unused control bits read back as zero
        ctrl_word = 32'h0000_0000;
        ctrl_word[SCH_CTRL_PORT_LSB +: SCH_PORTS] = link.port_supply_enable;
        ctrl_word[SCH_CTRL_OPTIC_LSB +: SCH_PORTS] =
            link.optic_supply_enable;
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave: address and data taken in either order
    assign do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;

    always_comb
    begin
        nxt_aw_hold = aw_hold_ff;
        nxt_aw_addr = aw_addr_ff;
        nxt_w_hold = w_hold_ff;
        nxt_w_data = w_data_ff;
        nxt_w_strb = w_strb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        nxt_ctrl = ctrl_ff;
        nxt_mask = mask_ff;
        nxt_irq = irq_ff;
        if (s_axi_awvalid && s_axi_awready)
        begin
            nxt_aw_hold = 1'b1;
            nxt_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            nxt_w_hold = 1'b1;
            nxt_w_data = s_axi_wdata;
            nxt_w_strb = s_axi_wstrb;
        end
        if (do_write)
        begin
            nxt_aw_hold = 1'b0;
            nxt_w_hold = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = known(aw_addr_ff) ? SCH_RESP_OKAY : SCH_RESP_SLVERR;
            if (aw_addr_ff == SCH_REG_CTRL)
            begin
                nxt_ctrl = merge(ctrl_ff, w_data_ff, w_strb_ff);
            end
            if (aw_addr_ff == SCH_REG_MASK)
            begin
                nxt_mask = SCH_IRQ_W'(merge({28'h0, mask_ff},
                                            w_data_ff, w_strb_ff));
            end
            if (aw_addr_ff == SCH_REG_IRQ && w_strb_ff[0])
            begin
                nxt_irq = irq_ff & ~w_data_ff[SCH_IRQ_W-1:0];
            end
        end
        // A new event wins over a clear in the same cycle
        nxt_irq = nxt_irq | events;
        if (bvalid_ff && s_axi_bready)
        begin
            nxt_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            nxt_rvalid = 1'b1;
            nxt_rresp = known(s_axi_araddr) ? SCH_RESP_OKAY : SCH_RESP_SLVERR;
            case (s_axi_araddr)
                SCH_REG_CTRL: nxt_rdata = ctrl_word;
                SCH_REG_STAT: nxt_rdata = status_word;
                SCH_REG_IRQ: nxt_rdata = {28'h0, irq_ff};
                SCH_REG_MASK: nxt_rdata = {28'h0, mask_ff};
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
        else if (rvalid_ff && s_axi_rready)
        begin
            nxt_rvalid = 1'b0;
        end
        if (!aresetn)
        begin
            nxt_aw_hold = 1'b0;
            nxt_w_hold = 1'b0;
            nxt_bvalid = 1'b0;
            nxt_rvalid = 1'b0;
            nxt_ctrl = SCH_CTRL_RESET;
            nxt_mask = SCH_MASK_RESET;
            nxt_irq = '0;
        end
    end

    always_ff @(posedge aclk)
    begin
        aw_hold_ff <= nxt_aw_hold;
        aw_addr_ff <= nxt_aw_addr;
        w_hold_ff <= nxt_w_hold;
        w_data_ff <= nxt_w_data;
        w_strb_ff <= nxt_w_strb;
        bvalid_ff <= nxt_bvalid;
        bresp_ff <= nxt_bresp;
        rvalid_ff <= nxt_rvalid;
        rdata_ff <= nxt_rdata;
        rresp_ff <= nxt_rresp;
        ctrl_ff <= nxt_ctrl;
        mask_ff <= nxt_mask;
        irq_ff <= nxt_irq;
    end

    // Ready only while the holding slot is empty
    assign s_axi_awready = aresetn && !aw_hold_ff;
    assign s_axi_wready = aresetn && !w_hold_ff;
    assign s_axi_arready = aresetn && !rvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign irq = |(irq_ff & mask_ff);
endmodule

// ---- test/sch_checker.sv ----
// Concurrent checks on the link between the platform and socket ends
`timescale 1ns/1ps
module sch_checker (
    input logic base_clock_40mhz,
    input logic socket_reset,
    input logic refclk_pll_locked,
    input logic refclk_valid_flag,
    input logic frontend_setup_done,
    input logic setup_prepare_request,
    input logic setup_prepare_ack,
    input logic spare_clock_output,
    input logic [sch_pkg::SCH_PORTS-1:0] port_supply_enable,
    input logic [sch_pkg::SCH_PORTS-1:0] port_supply_ok,
    input logic [sch_pkg::SCH_PORTS-1:0] optic_supply_enable,
    input logic [sch_pkg::SCH_PORTS-1:0] optic_supply_ok
);
    import sch_pkg::*;
    int low_cnt_ff, nxt_low_cnt;
    default clocking cb @(posedge base_clock_40mhz);
    endclocking
    default disable iff (socket_reset);
    ////////////////////////////////////////////////////////////////////////
    // Base cycles spent with setup done low since the last reset release
    always_comb
    begin
        if (socket_reset || frontend_setup_done)
            nxt_low_cnt = 0;
        else
            nxt_low_cnt = low_cnt_ff + 1;
    end
    // Register stage of the low-time counter
    always_ff @(posedge base_clock_40mhz)
    begin
        low_cnt_ff <= nxt_low_cnt;
    end
    ////////////////////////////////////////////////////////////////////////
    // Reserved handshake and spare clock
    chk_ack_from_prep: assert property (
        setup_prepare_ack == setup_prepare_request)
        else $error("prepare ack differs from prepare request");
    chk_spare_tied: assert property (!spare_clock_output)
        else $error("spare clock output not held low");
    // Clock health flags: valid implies locked
    chk_valid_locked: assert property (
        refclk_valid_flag |-> refclk_pll_locked)
        else $error("valid flag high without pll lock");
    // Setup done stays high unless a reset release is being handled
    chk_done_sticky: assert property (frontend_setup_done
        && !$past(socket_reset, 1) && !$past(socket_reset, 2)
        && !$past(socket_reset, 3) |=> frontend_setup_done)
        else $error("setup done dropped without reset release");
    // A reset release restarts configuration at once
    chk_rerun_setup: assert property ($fell(socket_reset)
        |-> ##[1:3] !frontend_setup_done)
        else $error("setup done not cleared after reset release");
    // Configuration takes the setup time, a few cycles of slack for edges
    chk_setup_length: assert property ($rose(frontend_setup_done)
        |-> low_cnt_ff >= SCH_SETUP_CYCLES - 4
        && low_cnt_ff <= SCH_SETUP_CYCLES + 4)
        else $error("setup done rose after wrong number of cycles");
    // Power good only follows an enable seen one base cycle earlier
    chk_port_ok_cause: assert property (
        (port_supply_ok & ~$past(port_supply_enable)) == '0)
        else $error("port power good without enable");
    chk_optic_ok_cause: assert property (
        (optic_supply_ok & ~$past(optic_supply_enable)) == '0)
        else $error("optic power good without enable");
endmodule

// ---- test/test_socket_clock_power_handshake.sv ----
// Testbench joining both ends over the link and driving the bus side
`timescale 1ns/1ps
module test_socket_clock_power_handshake;
    import sch_pkg::*;
    logic aclk, aresetn, base_clk, pll_locked_in, input_clock_ok, rlr, irq;
    logic [SCH_PORTS-1:0] port_op, optic_op;
    logic [SCH_PROBES-1:0] ucnt;
    logic [SCH_CNT_W-1:0] probe_count [SCH_PROBES];
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp;
    logic [33:0] exp_r [$];
    logic [1:0] exp_b [$];
    int bad_count, check_count;
    integer seed;
    sch_if lnk();
    ////////////////////////////////////////////////////////////////////////
    // Both ends face each other across the link
    sch_platform i_sch_platform (.base_clock_40mhz(base_clk),
        .pll_locked_in(pll_locked_in), .input_clock_ok(input_clock_ok),
        .port_overpower(port_op), .optic_overpower(optic_op),
        .probe_count(probe_count), .link(lnk.platform));
    sch_socket i_sch_socket (.aclk(aclk), .aresetn(aresetn),
        .base_clock_40mhz(base_clk), .user_clocks(ucnt),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .refclk_logic_reset(rlr), .irq(irq), .link(lnk.socket));
    sch_checker i_sch_checker (.base_clock_40mhz(base_clk),
        .socket_reset(lnk.socket_reset),
        .refclk_pll_locked(lnk.refclk_pll_locked),
        .refclk_valid_flag(lnk.refclk_valid_flag),
        .frontend_setup_done(lnk.frontend_setup_done),
        .setup_prepare_request(lnk.setup_prepare_request),
        .setup_prepare_ack(lnk.setup_prepare_ack),
        .spare_clock_output(lnk.spare_clock_output),
        .port_supply_enable(lnk.port_supply_enable),
        .port_supply_ok(lnk.port_supply_ok),
        .optic_supply_enable(lnk.optic_supply_enable),
        .optic_supply_ok(lnk.optic_supply_ok));
    ////////////////////////////////////////////////////////////////////////
    // Bus clock and the unrelated 40 MHz base clock
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    initial
    begin
        base_clk = 1'b0;
        forever #12.5 base_clk = ~base_clk;
    end
    // Probe k toggles every 2^k bus cycles, so rates are known exactly
    always @(posedge aclk)
        ucnt <= ucnt + 6'h01;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Responses are compared in order of issue as they appear
    always @(posedge aclk)
    begin
        if (bvalid && bready)
            check({32'h0, bresp}, {32'h0, exp_b.pop_front()});
        if (rvalid && rready)
            check({rresp, rdata}, exp_r.pop_front());
    end
    // Write: address and data offered together, each dropped when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] r);
        @(posedge aclk);
        exp_b.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        repeat (100)
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        if (!bvalid)
            bad_count++;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] r);
        @(posedge aclk);
        exp_r.push_back({r, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        repeat (100)
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        if (!rvalid)
            bad_count++;
        rready <= 1'b0;
    endtask
    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    // Bounded wait for configuration to finish
    task automatic wait_done();
        int n;
        n = 0;
        while (lnk.frontend_setup_done !== 1'b1 && n < 1000)
        begin
            @(posedge aclk);
            n++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        logic [31:0] d;
        logic [15:0] c0 [SCH_PROBES];
        seed = 32'hb9c6;
        bad_count = 0;
        check_count = 0;
        {aresetn, pll_locked_in, input_clock_ok, port_op, optic_op} = '0;
        {ucnt, awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
        {arvalid, rready} = '0;
        wstrb = 4'hf;
        do_reset();
        repeat (4) @(posedge aclk);
        check(lnk.refclk_valid_flag, 0);
        check(rlr, 1);
        check(lnk.socket_reset, 0);
        check(lnk.setup_prepare_ack, lnk.setup_prepare_request);
        check(lnk.spare_clock_output, 0);
        pll_locked_in <= 1'b1;
        repeat (4) @(posedge aclk);
        check(lnk.refclk_pll_locked, 1);
        check(lnk.refclk_valid_flag, 0);
        input_clock_ok <= 1'b1;
        repeat (4) @(posedge aclk);
        check(lnk.refclk_valid_flag, 1);
        check(rlr, 1);
        wait_done();
        check(lnk.frontend_setup_done, 1);
        repeat (10) @(posedge aclk);
        check(rlr, 0);
        axi_rd(SCH_REG_IRQ, 32'h3, SCH_RESP_OKAY);
        axi_wr(SCH_REG_MASK, 32'h1, SCH_RESP_OKAY);
        axi_rd(SCH_REG_MASK, 32'h1, SCH_RESP_OKAY);
        check(irq, 1);
        axi_wr(SCH_REG_IRQ, 32'h3, SCH_RESP_OKAY);
        axi_rd(SCH_REG_IRQ, 32'h0, SCH_RESP_OKAY);
        check(irq, 0);
        // Clock input lost then regained: logic held, then released
        input_clock_ok <= 1'b0;
        repeat (10) @(posedge aclk);
        check(rlr, 1);
        input_clock_ok <= 1'b1;
        repeat (10) @(posedge aclk);
        check(rlr, 0);
        check(irq, 1);
        axi_wr(SCH_REG_MASK, 32'h0, SCH_RESP_OKAY);
        // Random supply enables per port
        for (int i = 0; i < 4; i++)
        begin
            d = $random(seed);
            axi_wr(SCH_REG_CTRL, d, SCH_RESP_OKAY);
            axi_rd(SCH_REG_CTRL, d & 32'h3f3f, SCH_RESP_OKAY);
            repeat (6) @(posedge aclk);
            check(lnk.port_supply_enable, d[5:0]);
            check(lnk.optic_supply_enable, d[13:8]);
            check(lnk.port_supply_ok, d[5:0]);
            check(lnk.optic_supply_ok, d[13:8]);
            axi_rd(SCH_REG_STAT, (d & 32'h3f3f) | 32'h30000,
                   SCH_RESP_OKAY);
        end
        // Over-power drops power good and raises the drop events
        axi_wr(SCH_REG_CTRL, 32'h3f3f, SCH_RESP_OKAY);
        repeat (10) @(posedge aclk);
        axi_wr(SCH_REG_IRQ, 32'hf, SCH_RESP_OKAY);
        axi_rd(SCH_REG_IRQ, 32'h0, SCH_RESP_OKAY);
        d = $random(seed) | 32'h0101;
        port_op <= d[5:0];
        optic_op <= d[13:8];
        repeat (10) @(posedge aclk);
        check(lnk.port_supply_ok, d[5:0] ^ 6'h3f);
        check(lnk.optic_supply_ok, d[13:8] ^ 6'h3f);
        axi_rd(SCH_REG_IRQ, 32'hc, SCH_RESP_OKAY);
        axi_wr(SCH_REG_MASK, 32'hc, SCH_RESP_OKAY);
        axi_rd(SCH_REG_STAT, 32'h30000 | (~d & 32'h3f3f),
               SCH_RESP_OKAY);
        check(irq, 1);
        axi_wr(SCH_REG_IRQ, 32'hc, SCH_RESP_OKAY);
        axi_rd(SCH_REG_IRQ, 32'h0, SCH_RESP_OKAY);
        check(irq, 0);
        port_op <= '0;
        optic_op <= '0;
        // Unmapped address is refused and keeps nothing
        axi_wr(8'h10, 32'hffff_ffff, SCH_RESP_SLVERR);
        axi_rd(8'h10, 32'h0, SCH_RESP_SLVERR);
        // Debug probes: edge counts over a fixed span
        for (int k = 0; k < SCH_PROBES; k++)
            c0[k] = probe_count[k];
        repeat (256) @(posedge aclk);
        for (int k = 0; k < SCH_PROBES; k++)
        begin
            c0[k] = probe_count[k] - c0[k];
            check(c0[k] + 16'h1 >= 16'(128 >> k)
                && c0[k] <= 16'(128 >> k) + 16'h1, 1);
        end
        // Second reset in mid-run reruns configuration
        do_reset();
        repeat (10) @(posedge aclk);
        check(lnk.frontend_setup_done, 0);
        check(lnk.port_supply_enable, 0);
        check(rlr, 1);
        wait_done();
        check(lnk.frontend_setup_done, 1);
        repeat (10) @(posedge aclk);
        check(rlr, 0);
        final_report();
    end
    // Watchdog: the run needs a few thousand bus cycles at most
    initial
    begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        final_report();
    end
endmodule
